//--- hdl/fbp_map.vh
// Register map, field positions and reset values of the pin port
`ifndef FBP_MAP_VH
`define FBP_MAP_VH
// Register indices; the byte address on the bus is four times the index
`define FBP_DIR_OFFSET 16'hffd4
`define FBP_DATA_OFFSET 16'hffd6
`define FBP_CTL_OFFSET 16'hffd8
`define FBP_DIR_RESET 8'h00
`define FBP_DATA_RESET 8'h00
`define FBP_CTL_RESET 8'h00
`define FBP_DIR_READ 8'hff
`define FBP_CTL_PATTERN_LSB 0
`define FBP_CTL_HW_STANDBY_BIT 4
`define FBP_CTL_SW_STANDBY_BIT 5
`define FBP_CTL_EXT_STANDBY 0
`define FBP_ADDR_MASK 32'h0000ffff
`define FBP_PIN_COUNT 4
`endif

//--- hdl/fbp_sync.v
// Two-stage synchroniser for the port pin levels
`timescale 1ns/1ps
module fbp_sync #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Asynchronous in, synchronous out
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;

  always @(posedge mclk) begin
    if (rst) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // fbp_sync

//--- hdl/fbp_timer_sel.v
// Timer channel pin ownership decode for one channel pair (A and B pins)
`timescale 1ns/1ps
module fbp_timer_sel (
  // Channel settings
  input wire a_out_enable,
  input wire b_out_enable,
  input wire pulse_mode,
  input wire [2:0] a_ctl,
  input wire [2:0] b_ctl,
  // Decoded ownership
  output wire a_out_own,
  output wire b_out_own,
  output wire a_capture,
  output wire b_capture
);
  // Compare output when bit 2 clear and bits 1:0 nonzero
  function cmp_out;
    input [2:0] ctl;
    begin
      cmp_out = ~ctl[2] & (ctl[1] | ctl[0]);
    end
  endfunction

  assign a_out_own = a_out_enable & (pulse_mode | cmp_out(a_ctl));
  assign b_out_own = b_out_enable & cmp_out(b_ctl);
  assign a_capture = ~pulse_mode & a_ctl[2];
  assign b_capture = ~pulse_mode & b_ctl[2];
endmodule // fbp_timer_sel

//--- hdl/fbp_port.v
// Four-bit port with pattern and timer pin multiplexing, APB slave
// How it works
// - Four two-way pins, each also pattern output or timer 3/4 pin.
// - Pin selection is the same in every operating mode.
// - Direction register at ffd4, write-only, bits 3:0 used, 7:4 reserved.
// - Direction 1 makes a port output, 0 an input, unless timer owns.
// - Reading the direction register always returns all ones.
// - Direction register clears on reset and hardware standby.
// - Direction register holds through software standby, outputs keep driving.
// - Data register at ffd6, bits 3:0 are pin output values.
// - Data read: stored bit where direction is 1, pin level where 0.
// - Data bits 7:4 reserved but written and read back.
// - Data register clears on reset and hardware standby, holds in software.
// - No timer: dir 0 input, dir 1 port output or pattern output.
// - Pin 3 drives timer4 B output on enable and compare setting.
// - Pin 3 feeds timer4 B capture when pulse mode 0, ctl bit2 1.
// - Pin 2 drives timer4 A output on enable, pulse mode, combination mode bit 1 or compare.
// - Pin 2 feeds timer4 A capture when pulse mode 0, ctl bit2 1.
// - Pin 1 drives timer3 B output on enable and compare setting.
// - Pin 1 feeds timer3 B capture when pulse mode 0, ctl bit2 1.
// - Pin 0 drives timer3 A output on enable, pulse mode or compare.
// - Pin 0 feeds timer3 A capture when pulse mode 0, ctl bit2 1.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "fbp_map.vh"
module fbp_port #(
  parameter PINS = `FBP_PIN_COUNT
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Hardware standby request from the system
  input wire hw_standby,
  // Pattern controller
  input wire [3:0] pattern_out,
  // Timer channel 3 settings
  input wire timer3_a_out_enable,
  input wire timer3_b_out_enable,
  input wire timer3_pulse_mode,
  input wire [2:0] timer3_a_ctl,
  input wire [2:0] timer3_b_ctl,
  input wire timer3_a_out,
  input wire timer3_b_out,
  // Timer channel 4 settings
  input wire timer4_a_out_enable,
  input wire timer4_b_out_enable,
  input wire timer4_pulse_mode,
  input wire combination_mode_bit1,
  input wire [2:0] timer4_a_ctl,
  input wire [2:0] timer4_b_ctl,
  input wire timer4_a_out,
  input wire timer4_b_out,
  // Capture inputs to the timer
  output reg timer3_a_capture_in,
  output reg timer3_b_capture_in,
  output reg timer4_a_capture_in,
  output reg timer4_b_capture_in,
  // Pins
  input wire [3:0] pin_in,
  output reg [3:0] pin_out,
  output reg [3:0] pin_oe_n,
  // Status
  output reg standby_active
);
  reg [7:0] pin_direction_reg;
  reg [7:0] pin_direction_next;
  reg [7:0] pin_data_reg;
  reg [7:0] pin_data_next;
  reg [7:0] ctl_reg;
  reg [7:0] ctl_next;
  reg [31:0] rdata_next;
  reg err_next;
  reg [3:0] pin_out_next;
  reg [3:0] pin_oe_n_next;
  reg [3:0] tmr_own;
  reg [3:0] tmr_val;
  reg [1:0] pin_fn_code;
  reg hw_sb_meta_reg;
  reg hw_sb_reg;
  wire [3:0] pin_sync;
  wire [3:0] pattern_enable;
  wire hw_sb;
  wire sw_sb;
  wire setup;
  wire access;
  wire [1:0] bus_sel;
  wire t3a_own;
  wire t3b_own;
  wire t4a_own;
  wire t4b_own;
  wire t3a_cap;
  wire t3b_cap;
  wire t4a_cap;
  wire t4b_cap;
  integer i;

  // Register select codes from the word address decode
  localparam SEL_NONE = 2'h0;
  localparam SEL_DIR = 2'h1;
  localparam SEL_DATA = 2'h2;
  localparam SEL_CTL = 2'h3;

  // Pin function codes, timer output highest
  localparam FN_PORT_IN = 2'h0;
  localparam FN_PORT_OUT = 2'h1;
  localparam FN_PATTERN = 2'h2;
  localparam FN_TIMER = 2'h3;

  // Byte address is four times the register index; upper bits must be zero
  function [1:0] reg_sel;
    input [31:0] addr;
    reg [15:0] index;
    begin
      index = addr[17:2];
      reg_sel = SEL_NONE;
      if (addr[31:18] == 14'h0000 && addr[1:0] == 2'h0) begin
        case (index)
          `FBP_DIR_OFFSET: reg_sel = SEL_DIR;
          `FBP_DATA_OFFSET: reg_sel = SEL_DATA;
          `FBP_CTL_OFFSET: reg_sel = SEL_CTL;
          default: reg_sel = SEL_NONE;
        endcase
      end
    end
  endfunction

  // Timer output owns the pin first, then direction and pattern enable
  function [1:0] pin_fn;
    input own;
    input dir;
    input pat_en;
    begin
      if (own)
        pin_fn = FN_TIMER;
      else if (!dir)
        pin_fn = FN_PORT_IN;
      else if (pat_en)
        pin_fn = FN_PATTERN;
      else
        pin_fn = FN_PORT_OUT;
    end
  endfunction

  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign bus_sel = reg_sel(paddr);
  assign pattern_enable = ctl_reg[`FBP_CTL_PATTERN_LSB+3:`FBP_CTL_PATTERN_LSB];
  assign hw_sb = hw_sb_reg | ctl_reg[`FBP_CTL_HW_STANDBY_BIT];
  assign sw_sb = ctl_reg[`FBP_CTL_SW_STANDBY_BIT];

  // Pin levels pass two flip-flops before use
  fbp_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  fbp_timer_sel u_tmr3 (
    .a_out_enable(timer3_a_out_enable),
    .b_out_enable(timer3_b_out_enable),
    .pulse_mode(timer3_pulse_mode),
    .a_ctl(timer3_a_ctl),
    .b_ctl(timer3_b_ctl),
    .a_out_own(t3a_own),
    .b_out_own(t3b_own),
    .a_capture(t3a_cap),
    .b_capture(t3b_cap)
  );

  fbp_timer_sel u_tmr4 (
    .a_out_enable(timer4_a_out_enable),
    .b_out_enable(timer4_b_out_enable),
    .pulse_mode(timer4_pulse_mode | combination_mode_bit1),
    .a_ctl(timer4_a_ctl),
    .b_ctl(timer4_b_ctl),
    .a_out_own(t4a_own),
    .b_out_own(t4b_own),
    .a_capture(),
    .b_capture()
  );

  // Capture decode for channel 4 uses pulse mode alone
  assign t4a_cap = ~timer4_pulse_mode & timer4_a_ctl[2];
  assign t4b_cap = ~timer4_pulse_mode & timer4_b_ctl[2];

  // Standby request is an outside level
  always @(posedge mclk) begin
    if (rst) begin
      hw_sb_meta_reg <= 1'b0;
      hw_sb_reg <= 1'b0;
    end else begin
      hw_sb_meta_reg <= hw_standby;
      hw_sb_reg <= hw_sb_meta_reg;
    end
  end

  // Writes land at the access edge, where the answer is sampled
  always @* begin
    pin_direction_next = pin_direction_reg;
    pin_data_next = pin_data_reg;
    ctl_next = ctl_reg;
    if (access && pwrite) begin
      case (bus_sel)
        SEL_DIR: begin
          pin_direction_next = pwdata[7:0];
        end
        SEL_DATA: begin
          pin_data_next = pwdata[7:0];
        end
        SEL_CTL: begin
          ctl_next = pwdata[7:0];
        end
        default: begin
          ctl_next = ctl_reg;
        end
      endcase
    end
    // Hardware standby clears both port registers; software standby holds
    if (hw_sb) begin
      pin_direction_next = `FBP_DIR_RESET;
      pin_data_next = `FBP_DATA_RESET;
    end
  end

  // Read data and refusal, registered with the answer
  always @* begin
    rdata_next = 32'h00000000;
    err_next = 1'b0;
    if (setup) begin
      case (bus_sel)
        SEL_DIR: begin
          rdata_next = {24'h000000, `FBP_DIR_READ};
        end
        SEL_DATA: begin
          // Pin level where input, stored bit where output
          rdata_next = {24'h000000, pin_data_reg[7:4],
            (pin_data_reg[3:0] & pin_direction_reg[3:0]) |
            (pin_sync & ~pin_direction_reg[3:0])};
        end
        SEL_CTL: begin
          rdata_next = {24'h000000, ctl_reg};
        end
        default: begin
          err_next = 1'b1;
        end
      endcase
    end
  end

  // Pin function priority: timer output, then port input, then pattern, then port output
  always @* begin
    tmr_own = {t4b_own, t4a_own, t3b_own, t3a_own};
    tmr_val = {timer4_b_out, timer4_a_out, timer3_b_out, timer3_a_out};
    pin_out_next = 4'h0;
    pin_oe_n_next = 4'hf;
    pin_fn_code = FN_PORT_IN;
    for (i = 0; i < PINS; i = i + 1) begin
      pin_fn_code = pin_fn(tmr_own[i], pin_direction_reg[i],
        pattern_enable[i]);
      case (pin_fn_code)
        FN_TIMER: begin
          pin_out_next[i] = tmr_val[i];
          pin_oe_n_next[i] = 1'b0;
        end
        FN_PATTERN: begin
          pin_out_next[i] = pattern_out[i];
          pin_oe_n_next[i] = 1'b0;
        end
        FN_PORT_OUT: begin
          pin_out_next[i] = pin_data_reg[i];
          pin_oe_n_next[i] = 1'b0;
        end
        default: begin
          pin_out_next[i] = 1'b0;
          pin_oe_n_next[i] = 1'b1;
        end
      endcase
    end
  end

  // Port registers
  always @(posedge mclk) begin
    if (rst) begin
      pin_direction_reg <= `FBP_DIR_RESET;
      pin_data_reg <= `FBP_DATA_RESET;
      ctl_reg <= `FBP_CTL_RESET;
    end else begin
      pin_direction_reg <= pin_direction_next;
      pin_data_reg <= pin_data_next;
      ctl_reg <= ctl_next;
    end
  end

  // Bus answer: one wait-free access cycle per transfer
  always @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= rdata_next;
      pready <= setup;
      pslverr <= err_next;
    end
  end

  // Pin drive, capture levels and standby status
  always @(posedge mclk) begin
    if (rst) begin
      pin_out <= 4'h0;
      pin_oe_n <= 4'hf;
      timer3_a_capture_in <= 1'b0;
      timer3_b_capture_in <= 1'b0;
      timer4_a_capture_in <= 1'b0;
      timer4_b_capture_in <= 1'b0;
      standby_active <= 1'b0;
    end else begin
      pin_out <= pin_out_next;
      pin_oe_n <= pin_oe_n_next;
      // Capture inputs follow the pin level whatever the pin drives
      timer3_a_capture_in <= t3a_cap & pin_sync[0];
      timer3_b_capture_in <= t3b_cap & pin_sync[1];
      timer4_a_capture_in <= t4a_cap & pin_sync[2];
      timer4_b_capture_in <= t4b_cap & pin_sync[3];
      standby_active <= hw_sb | sw_sb;
    end
  end
endmodule // fbp_port

//--- verification/fbp_port_chk.sv
// Assertions on the pin port
`timescale 1ns/1ps
module fbp_port_chk (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  // Standby and timers
  input wire hw_standby,
  input wire timer3_a_out_enable,
  input wire timer3_pulse_mode,
  input wire [2:0] timer3_a_ctl,
  input wire timer3_a_out,
  input wire timer3_a_capture_in,
  input wire timer3_b_capture_in,
  input wire timer4_b_out_enable,
  input wire [2:0] timer4_b_ctl,
  input wire timer4_b_out,
  // Pins
  input wire [3:0] pin_in,
  input wire [3:0] pin_out,
  input wire [3:0] pin_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no answer");
  property p_dir;
    psel && !penable && !pwrite && paddr == 32'h0003ff50
      |=> prdata[7:0] == 8'hff;
  endproperty
  a_dir: assert property (p_dir) else $error("dir read");
  property p_rst; $fell(rst) |-> pin_oe_n == 4'hf && !pready; endproperty
  a_rst: assert property (p_rst) else $error("reset pins");
  property p_hw; hw_standby[*7] |-> pin_oe_n == 4'hf; endproperty
  a_hw: assert property (p_hw) else $error("standby pins");
  property p_cap;
    (!timer3_pulse_mode && timer3_a_ctl[2] && pin_in[0])[*5]
      |-> timer3_a_capture_in;
  endproperty
  a_cap: assert property (p_cap) else $error("capture");
  property p_capoff;
    timer3_pulse_mode[*3] |-> !timer3_a_capture_in && !timer3_b_capture_in;
  endproperty
  a_capoff: assert property (p_capoff) else $error("capture off");
  property p_own0;
    (timer3_a_out_enable && timer3_pulse_mode && !timer3_a_out)[*3]
      |-> !pin_oe_n[0] && !pin_out[0];
  endproperty
  a_own0: assert property (p_own0) else $error("pin 0 timer");
  property p_own3;
    (timer4_b_out_enable && timer4_b_ctl == 3'h1 && !timer4_b_out)[*3]
      |-> !pin_oe_n[3] && !pin_out[3];
  endproperty
  a_own3: assert property (p_own3) else $error("pin 3 timer");
  c_wr: cover property (psel && penable && pready && pwrite);
  c_hw: cover property (hw_standby[*7]);
  c_cap: cover property (timer3_a_capture_in);
endmodule // fbp_port_chk
bind fbp_port fbp_port_chk u_fbp_port_chk (.*);

//--- verification/fbp_board.sv
// Board model giving the level on each port pin
`timescale 1ns/1ps
module fbp_board (
  // Device side
  input wire [3:0] pin_out,
  input wire [3:0] pin_oe_n,
  // Outside circuits
  input wire [3:0] ext_level,
  output wire [3:0] pin_in
);
  // A driven pin reads back its own level
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule // fbp_board

//--- verification/fbp_port_tb.sv
// Self-checking bench for the pin port
`timescale 1ns/1ps
module fbp_port_tb;
  reg mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, hw_standby = 0;
  reg [31:0] paddr = 0, pwdata = 0;
  wire [31:0] prdata;
  wire pready, pslverr, standby_active;
  reg [3:0] pattern_out = 0, ext = 4'ha;
  reg timer3_a_out_enable = 0, timer3_b_out_enable = 0, timer3_pulse_mode = 0;
  reg timer4_a_out_enable = 0, timer4_b_out_enable = 0, timer4_pulse_mode = 0;
  reg timer3_a_out = 0, timer3_b_out = 0, timer4_a_out = 0, timer4_b_out = 0;
  reg combination_mode_bit1 = 0;
  reg [2:0] timer3_a_ctl = 0, timer3_b_ctl = 0;
  reg [2:0] timer4_a_ctl = 0, timer4_b_ctl = 0;
  wire timer3_a_capture_in, timer3_b_capture_in;
  wire timer4_a_capture_in, timer4_b_capture_in;
  wire [3:0] pin_in, pin_out, pin_oe_n;
  reg [7:0] rdat;
  reg rerr;
  integer fail_count = 0, tests_run = 0;
  always #5 mclk = ~mclk;
  fbp_port u_fbp_port (.*);
  fbp_board u_fbp_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_level(ext), .pin_in(pin_in));
  task idle(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("BAD %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task apb(input [15:0] a, input dr, input [7:0] d);
    begin
      psel <= 1;
      pwrite <= dr;
      paddr <= {14'h0000, a, 2'h0};
      pwdata <= {24'h000000, d};
      @(posedge mclk);
      penable <= 1;
      do begin
        @(posedge mclk);
      end while (pready !== 1'b1);
      rdat = prdata[7:0];
      rerr = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge mclk);
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      apb(a, 1'b0, 8'h00);
      chk("prdata", e, rdat);
    end
  endtask
  task final_report;
    begin
      if (fail_count == 0 && tests_run > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    #100000;
    fail_count = fail_count + 1;
    final_report;
  end
  initial begin
    idle(20);
    rst <= 0;
    idle(1);
    rd(16'hffd4, 8'hff);
    rd(16'hffd6, 8'h0a);
    apb(16'hffd4, 1'b1, 8'h0f);
    apb(16'hffd6, 1'b1, 8'ha5);
    rd(16'hffd6, 8'ha5);
    rd(16'hffd4, 8'hff);
    chk("pins", 8'h05, {pin_oe_n, pin_out});
    apb(16'hffd4, 1'b1, 8'h03);
    idle(3);
    rd(16'hffd6, 8'ha9);
    chk("pins", 8'hc1, {pin_oe_n, pin_out & 4'h3});
    pattern_out <= 4'h2;
    apb(16'hffd8, 1'b1, 8'h03);
    idle(2);
    chk("pins", 8'hc2, {pin_oe_n, pin_out & 4'h3});
    apb(16'hffd8, 1'b1, 8'h23);
    idle(2);
    chk("pins", 8'hc2, {pin_oe_n, pin_out & 4'h3});
    chk("standby", 8'h01, {7'h00, standby_active});
    rd(16'hffd6, 8'ha9);
    apb(16'hffd8, 1'b1, 8'h00);
    {timer3_a_out_enable, timer3_pulse_mode, timer3_b_out_enable} <= 3'h7;
    {timer4_a_out_enable, combination_mode_bit1, timer4_b_out_enable} <= 3'h7;
    {timer3_b_ctl, timer4_a_ctl, timer4_b_ctl} <= {3'h2, 3'h4, 3'h1};
    {timer4_b_out, timer4_a_out, timer3_b_out, timer3_a_out} <= 4'h6;
    idle(3);
    chk("pins", 8'h06, {pin_oe_n, pin_out});
    chk("standby", 8'h00, {7'h00, standby_active});
    {timer3_a_out_enable, timer3_pulse_mode, timer3_b_out_enable} <= 3'h0;
    {timer4_a_out_enable, combination_mode_bit1, timer4_b_out_enable} <= 3'h0;
    {timer4_pulse_mode, timer3_a_ctl, ext} <= {1'b1, 3'h4, 4'hf};
    idle(6);
    chk("capture", 8'h01, {4'h0, timer4_b_capture_in, timer4_a_capture_in,
      timer3_b_capture_in, timer3_a_capture_in});
    {timer4_pulse_mode, timer4_b_ctl} <= {1'b0, 3'h4};
    idle(6);
    chk("capture", 8'h0d, {4'h0, timer4_b_capture_in, timer4_a_capture_in,
      timer3_b_capture_in, timer3_a_capture_in});
    hw_standby <= 1;
    idle(8);
    chk("standby", 8'h01, {7'h00, standby_active});
    hw_standby <= 0;
    idle(4);
    chk("pins", 8'hf0, {pin_oe_n, 4'h0});
    rd(16'hffd6, 8'h0f);
    apb(16'hffd4, 1'b1, 8'h0f);
    apb(16'hffd6, 1'b1, 8'ha5);
    apb(16'hffd8, 1'b1, 8'h10);
    idle(4);
    chk("pins", 8'hf0, {pin_oe_n, 4'h0});
    rd(16'hffd6, 8'h0f);
    apb(16'hffe0, 1'b0, 8'h00);
    chk("pslverr", 8'h01, {7'h00, rerr});
    final_report;
  end
endmodule // fbp_port_tb
